// File: logic/pss_defs.svh
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// --------------------------------------------------------------------------
// widths and timing
// --------------------------------------------------------------------------
`define PSS_NUM_BLOCKS 8
`define PSS_CLK_PERIOD_NS 10
// oscillator and pll settle time in ns, checked after both report ready
`define PSS_SETTLE_NS 200
`define PSS_SETTLE_CYCLES ((`PSS_SETTLE_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)
`define PSS_CNT_W 8
// reset value of the clock control enables
`define PSS_CLK_CTRL_RST 8'h00

`endif

// File: logic/pss_pkg.sv
package pss_pkg;
  // --------------------------------------------------------------------------
  // power states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PSS_OFF = 3'b000,
    PSS_RETENTION_ONLY_STATE = 3'b001,
    PSS_SLEEP = 3'b010,
    PSS_WAKEUP = 3'b011,
    PSS_POWERED_ON_STATE = 3'b100
  } pss_state_t;
endpackage

// File: logic/pss_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for one asynchronous level
module pss_sync
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } pss_sync_st_t;

  pss_sync_st_t st;
  pss_sync_st_t next_st;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign q_out = st.s2;
endmodule // pss_sync

// File: logic/pss_clk_gate.sv
`timescale 1ns/1ps
// latch-free enable gate: a registered enable per block, block may add its own
module pss_clk_gate
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic top_en_in,
  input wire logic local_en_in,
  output logic gate_out
);
  typedef struct packed {
    logic en;
  } pss_gate_st_t;

  pss_gate_st_t st;
  pss_gate_st_t next_st;

  // --------------------------------------------------------------------------
  // combined enable
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.en = top_en_in & local_en_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign gate_out = st.en;
endmodule // pss_clk_gate

// File: logic/pss_sequencer.sv
`timescale 1ns/1ps
`include "pss_defs.svh"
// Summary of operation
// R1 - power-down pin low: rtc off, every register cleared
// R2 - retention-only state powers only the rtc domain
// R3 - retention memory stays powered through the retention-only state
// R4 - sleep runs only rtc logic, oscillator off
// R5 - any mac, host, rtc timer or external event wakes from sleep
// R6 - entering wakeup enables oscillator and plls
// R7 - wakeup is the only path from sleep states to on
// R8 - in on, clock goes only to blocks enabled in clock control
// R9 - each block may gate its clock locally as well
// R10 - in on, cpu clock stops while wait instruction is executing
// R11 - leave wakeup only after oscillator stable and plls locked
// R12 - power-down pin low forces off from any state
module pss_sequencer
  import pss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic power_down_pin_n_in,
  input wire logic mac_wake_in,
  input wire logic host_wake_in,
  input wire logic rtc_timer_wake_in,
  input wire logic ext_irq_wake_in,
  input wire logic sleep_req_in,
  input wire logic retention_req_in,
  input wire logic xtal_stable_in,
  input wire logic pll_locked_in,
  input wire logic wait_for_interrupt_instruction_in,
  input wire logic cpu_irq_in,
  input wire logic clk_ctrl_we_in,
  input wire logic [`PSS_NUM_BLOCKS-1:0] clk_ctrl_in,
  input wire logic [`PSS_NUM_BLOCKS-1:0] block_local_en_in,
  output logic [2:0] state_out,
  output logic rtc_enable_out,
  output logic rtc_power_out,
  output logic retention_mem_power_out,
  output logic main_power_out,
  output logic xtal_enable_out,
  output logic pll_enable_out,
  output logic regs_clear_out,
  output logic hs_clk_run_out,
  output logic cpu_clk_en_out,
  output logic [`PSS_NUM_BLOCKS-1:0] block_clk_en_out,
  output logic [`PSS_NUM_BLOCKS-1:0] clk_ctrl_out
);

  // --------------------------------------------------------------------------
  // state record
  // --------------------------------------------------------------------------
  typedef struct packed {
    pss_state_t state;
    logic rtc_enable;
    logic rtc_power;
    logic ret_power;
    logic main_power;
    logic xtal_en;
    logic pll_en;
    logic regs_clear;
    logic hs_run;
    logic cpu_en;
    logic cpu_waiting;
    logic [`PSS_CNT_W-1:0] settle_cnt;
    logic [`PSS_NUM_BLOCKS-1:0] clk_ctrl;
  } pss_seq_st_t;

  pss_seq_st_t st;
  pss_seq_st_t next_st;

  logic pd_n_s;
  logic mac_s;
  logic host_s;
  logic rtc_s;
  logic ext_s;
  logic xtal_s;
  logic pll_s;
  logic any_wake;
  logic clocks_ready;
  logic [`PSS_NUM_BLOCKS-1:0] gated_en;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  // all pin inputs cross two flops; power-down is a pin, so it is no exception
  // power-down pin; the synchroniser resets low, so reset release starts in off
  pss_sync u_sync_pd
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(power_down_pin_n_in),
    .q_out(pd_n_s)
  );

  // mac wake event
  pss_sync u_sync_mac
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(mac_wake_in),
    .q_out(mac_s)
  );

  // host wake request
  pss_sync u_sync_host
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(host_wake_in),
    .q_out(host_s)
  );

  // rtc timer expiry
  pss_sync u_sync_rtc
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(rtc_timer_wake_in),
    .q_out(rtc_s)
  );

  // external interrupt wake
  pss_sync u_sync_ext
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(ext_irq_wake_in),
    .q_out(ext_s)
  );

  // oscillator stable status, comes from the analog side
  pss_sync u_sync_xtal
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(xtal_stable_in),
    .q_out(xtal_s)
  );

  // pll lock status, comes from the analog side
  pss_sync u_sync_pll
  (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .d_in(pll_locked_in),
    .q_out(pll_s)
  );

  // wake and ready terms read only the second flop of each synchroniser
  assign any_wake = mac_s | host_s | rtc_s | ext_s; // R5
  assign clocks_ready = xtal_s & pll_s; // R11

  // --------------------------------------------------------------------------
  // per-block clock gates
  // --------------------------------------------------------------------------
  // top enable only while on and running; local enable lets a block cut itself
  genvar gi;
  generate
    for (gi = 0; gi < `PSS_NUM_BLOCKS; gi++)
    begin : g_gate
      pss_clk_gate u_gate (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .top_en_in(st.hs_run & st.clk_ctrl[gi]), // R8
        .local_en_in(block_local_en_in[gi]), // R9
        .gate_out(gated_en[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state machine and power outputs
  // --------------------------------------------------------------------------
  // next state; the pin override comes last so that nothing can outvote it
  always_comb
  begin
    next_st = st;
    // clock control is ordinary state, written from the same-clock side
    if (clk_ctrl_we_in)
      next_st.clk_ctrl = clk_ctrl_in;
    case (st.state)
      PSS_OFF:
      begin
        // leave off once the pin has been released
        if (pd_n_s)
          next_st.state = PSS_WAKEUP;
      end

      PSS_RETENTION_ONLY_STATE:
      begin
        // a wake event leaves, always through wakeup; only the pin override leaves to off instead
        if (any_wake)
          next_st.state = PSS_WAKEUP; // R7
      end

      PSS_SLEEP:
      begin
        // same wake sources as retention; the oscillator is still off here
        if (any_wake)
          next_st.state = PSS_WAKEUP; // R5
      end

      PSS_WAKEUP:
      begin
        // counter starts only once both report ready, to ride over glitches
        if (!clocks_ready)
          next_st.settle_cnt = '0;
        else if (st.settle_cnt != `PSS_CNT_W'(`PSS_SETTLE_CYCLES))
          next_st.settle_cnt = st.settle_cnt + `PSS_CNT_W'(1);
        else
          next_st.state = PSS_POWERED_ON_STATE; // R11
      end

      PSS_POWERED_ON_STATE:
      begin
        // retention wins when both requests arrive in one cycle
        if (retention_req_in)
          next_st.state = PSS_RETENTION_ONLY_STATE;
        else if (sleep_req_in)
          next_st.state = PSS_SLEEP;
      end

      default:
      begin
        // unused codes fall back to off rather than hang
        next_st.state = PSS_OFF;
      end
    endcase

    // the settle count only means something inside wakeup
    if (next_st.state != PSS_WAKEUP)
      next_st.settle_cnt = '0;

    // cpu waits from the instruction until an interrupt arrives
    // an interrupt in the same cycle wins, so a wait cannot swallow it
    if (next_st.state != PSS_POWERED_ON_STATE)
      next_st.cpu_waiting = 1'h0;
    else if (cpu_irq_in)
      next_st.cpu_waiting = 1'h0;
    else if (wait_for_interrupt_instruction_in)
      next_st.cpu_waiting = 1'h1; // R10

    // power-down overrides everything, wake events included
    if (!pd_n_s)
    begin
      next_st = '0; // R12
      next_st.state = PSS_OFF; // R1
    end

    // derive supply controls from the coming state, so they move with it
    next_st.rtc_enable = (next_st.state != PSS_OFF); // R1
    next_st.rtc_power = (next_st.state != PSS_OFF);
    next_st.ret_power = (next_st.state != PSS_OFF); // R3
    next_st.regs_clear = (next_st.state == PSS_OFF); // R1
    // main supply, oscillator and plls only in wakeup and on
    next_st.main_power = (next_st.state == PSS_WAKEUP) ||
      (next_st.state == PSS_POWERED_ON_STATE); // R2
    next_st.xtal_en = next_st.main_power; // R4 R6
    next_st.pll_en = next_st.main_power; // R6
    // clock distribution and the cpu clock only in on
    next_st.hs_run = (next_st.state == PSS_POWERED_ON_STATE);
    next_st.cpu_en = next_st.hs_run & ~next_st.cpu_waiting; // R10
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // ce low freezes the whole record; reset lands in off with the clear raised
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st <= '0;
      st.regs_clear <= 1'h1;
      st.clk_ctrl <= `PSS_CLK_CTRL_RST;
    end
    else if (ce_in)
      st <= next_st;
  end

  // --------------------------------------------------------------------------
  // outputs, all straight from flops
  // --------------------------------------------------------------------------
  // power state and supplies
  assign state_out = st.state;
  assign rtc_enable_out = st.rtc_enable;
  assign rtc_power_out = st.rtc_power;
  assign retention_mem_power_out = st.ret_power;
  assign main_power_out = st.main_power;
  assign xtal_enable_out = st.xtal_en;
  assign pll_enable_out = st.pll_en;
  assign regs_clear_out = st.regs_clear;
  // clock controls; block enables come from the per-block gate flops
  assign hs_clk_run_out = st.hs_run;
  assign cpu_clk_en_out = st.cpu_en;
  assign block_clk_en_out = gated_en;
  assign clk_ctrl_out = st.clk_ctrl;

endmodule // pss_sequencer

// File: test/pss_chk.sv
`timescale 1ns/1ps
`include "pss_defs.svh"
// --------------------------------------------------------------------------
// power sequencer checker
// --------------------------------------------------------------------------
module pss_chk
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic power_down_pin_n_in,
  input wire logic mac_wake_in,
  input wire logic host_wake_in,
  input wire logic rtc_timer_wake_in,
  input wire logic ext_irq_wake_in,
  input wire logic xtal_stable_in,
  input wire logic pll_locked_in,
  input wire logic wait_for_interrupt_instruction_in,
  input wire logic cpu_irq_in,
  input wire logic [`PSS_NUM_BLOCKS-1:0] block_local_en_in,
  input wire logic [2:0] state_out,
  input wire logic rtc_enable_out,
  input wire logic rtc_power_out,
  input wire logic retention_mem_power_out,
  input wire logic main_power_out,
  input wire logic xtal_enable_out,
  input wire logic pll_enable_out,
  input wire logic regs_clear_out,
  input wire logic hs_clk_run_out,
  input wire logic cpu_clk_en_out,
  input wire logic [`PSS_NUM_BLOCKS-1:0] block_clk_en_out,
  input wire logic [`PSS_NUM_BLOCKS-1:0] clk_ctrl_out
);
  logic wk;
  // any wake source, pin must stay high or off wins
  assign wk = (mac_wake_in | host_wake_in | rtc_timer_wake_in | ext_irq_wake_in);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_off_clear: assert property (state_out == 3'h0 |-> regs_clear_out && !rtc_enable_out)
    else $error("off state without clear");
  a_ret_power: assert property (state_out == 3'h1 |-> rtc_power_out && !main_power_out)
    else $error("retention power wrong");
  a_ret_mem: assert property (state_out == 3'h1 |-> retention_mem_power_out)
    else $error("retention memory unpowered");
  a_sleep_xtal: assert property (state_out == 3'h2 |-> rtc_enable_out && !xtal_enable_out)
    else $error("sleep oscillator on");
  a_wake_any: assert property ((state_out == 3'h2 && wk && power_down_pin_n_in) ##1
    (wk && power_down_pin_n_in) [*3] |-> state_out == 3'h3)
    else $error("wake event ignored");
  a_wake_osc: assert property (state_out == 3'h3 |-> xtal_enable_out && pll_enable_out)
    else $error("wakeup without oscillator");
  a_wake_path: assert property (state_out == 3'h4 |-> $past(state_out) inside {3'h3, 3'h4})
    else $error("on entered not from wakeup");
  a_block_gate: assert property (block_clk_en_out == ($past(clk_ctrl_out) &
    $past(block_local_en_in) & {`PSS_NUM_BLOCKS{$past(hs_clk_run_out)}}))
    else $error("block clock enable wrong");
  a_cpu_wait: assert property ((state_out == 3'h4 && wait_for_interrupt_instruction_in
    && !cpu_irq_in) |=> !cpu_clk_en_out)
    else $error("cpu clock not gated");
  a_ready_wait: assert property ($rose(hs_clk_run_out) |-> $past(xtal_stable_in, 3)
    && $past(pll_locked_in, 3))
    else $error("on before clocks ready");
  a_pin_off: assert property (!power_down_pin_n_in [*4] |-> state_out == 3'h0)
    else $error("pin low not off");
  c_on: cover property (state_out == 3'h3 ##1 state_out == 3'h4);
  c_ret: cover property (state_out == 3'h1);
  c_wait: cover property (state_out == 3'h4 && !cpu_clk_en_out);
endmodule // pss_chk

// File: test/tb_top.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// power sequencer bench
// --------------------------------------------------------------------------
module tb_top;
  logic clk, rstn, pin, slp, ret, xs, pl, wfi, irq, we;
  logic [3:0] wk;
  logic [7:0] cc, le, bce, cco;
  logic [2:0] st;
  logic rtc_en, rtc_pw, rm_pw, mp, xe, pe, rc, hs, ce_o;
  int error_cnt = 0;
  int checks = 0;
  // ce held high: the freeze has no rule of its own to check here
  pss_sequencer pss_sequencer_inst (.core_clk_in(clk), .rstn_in(rstn), .ce_in(1'h1),
    .power_down_pin_n_in(pin), .mac_wake_in(wk[0]), .host_wake_in(wk[1]),
    .rtc_timer_wake_in(wk[2]), .ext_irq_wake_in(wk[3]), .sleep_req_in(slp),
    .retention_req_in(ret), .xtal_stable_in(xs), .pll_locked_in(pl),
    .wait_for_interrupt_instruction_in(wfi), .cpu_irq_in(irq), .clk_ctrl_we_in(we),
    .clk_ctrl_in(cc), .block_local_en_in(le), .state_out(st), .rtc_enable_out(rtc_en),
    .rtc_power_out(rtc_pw), .retention_mem_power_out(rm_pw), .main_power_out(mp),
    .xtal_enable_out(xe), .pll_enable_out(pe), .regs_clear_out(rc), .hs_clk_run_out(hs),
    .cpu_clk_en_out(ce_o), .block_clk_en_out(bce), .clk_ctrl_out(cco));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // calls pass the value seen first and the value the rule expects second
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait: a hang ends the run instead of stalling it
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (st !== s && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (st !== s)
    begin
      error_cnt++;
      $display("mismatch state_wait expected %h seen %h", s, st);
      give_verdict();
    end
  endtask
  task automatic t_boot();
    pin = 1'h1;
    wait_st(3'h3);
    chk("xtal_pll", 8'({xe, pe}), 8'h03);
    repeat (40) @(negedge clk);
    chk("state_hold", 8'(st), 8'h03);
    xs = 1'h1;
    pl = 1'h1;
    wait_st(3'h4);
    chk("hs_run", 8'(hs), 8'h01);
  endtask
  task automatic t_clk();
    cc = 8'ha5;
    le = 8'h0f;
    we = 1'h1;
    @(negedge clk);
    we = 1'h0;
    chk("clk_ctrl", cco, 8'ha5);
    @(negedge clk);
    chk("blk_en", bce, 8'h05);
    le = 8'hf0;
    @(negedge clk);
    chk("blk_local", bce, 8'ha0);
  endtask
  task automatic t_wait();
    wfi = 1'h1;
    @(negedge clk);
    wfi = 1'h0;
    chk("cpu_gated", 8'(ce_o), 8'h00);
    irq = 1'h1;
    @(negedge clk);
    irq = 1'h0;
    chk("cpu_run", 8'(ce_o), 8'h01);
  endtask
  task automatic t_sleep(input int i);
    slp = 1'h1;
    @(negedge clk);
    slp = 1'h0;
    chk("sleep", 8'({st, xe, rtc_en}), 8'h09);
    wk[i] = 1'h1;
    wait_st(3'h3);
    wk = 4'h0;
    wait_st(3'h4);
  endtask
  task automatic t_ret();
    ret = 1'h1;
    slp = 1'h1;
    @(negedge clk);
    ret = 1'h0;
    slp = 1'h0;
    chk("ret", 8'({st, mp, rtc_pw}), 8'h05);
    chk("ret_mem", 8'(rm_pw), 8'h01);
    wk = 4'h2;
    wait_st(3'h3);
    wk = 4'h0;
    wait_st(3'h4);
  endtask
  task automatic t_pin();
    wk = 4'hf;
    pin = 1'h0;
    wait_st(3'h0);
    repeat (10) @(negedge clk);
    chk("off", 8'({st, rc, rtc_en}), 8'h02);
    chk("off_ctrl", cco, 8'h00);
  endtask
  // free-running 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // main sequence, inputs change on the falling edge
  initial
  begin
    {rstn, pin, slp, ret, xs, pl, wfi, irq, we, wk, cc, le} = '0;
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    t_boot();
    t_clk();
    t_wait();
    for (int i = 0; i < 4; i++)
      t_sleep(i);
    t_ret();
    t_pin();
    give_verdict();
  end
endmodule // tb_top
bind pss_sequencer pss_chk pss_chk_inst (.*);
